// ==== common/flash_status_regs.vh ====
// Status register bit positions, reset values and default opcodes
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

// Status register layout
`define STATUS_REG_WIDTH          8
`define STATUS_REG_READY_BIT      7
`define STATUS_REG_ERASE_SUSP_BIT 6
`define STATUS_REG_ERASE_FAIL_BIT 5
`define STATUS_REG_PROG_FAIL_BIT  4
`define STATUS_REG_VPP_LOW_BIT    3
`define STATUS_REG_PROG_SUSP_BIT  2
`define STATUS_REG_LOCK_ABORT_BIT 1
`define STATUS_REG_PART_BUSY_BIT  0

// Reset values
`define STATUS_REG_STICKY_RESET   6'h00
`define DATA_RESET            16'h0000
`define STATUS_HIGH_BYTE      8'h00

// Geometry
`define NUM_PARTITIONS        8
`define PART_ADDR_BITS        3
`define DATA_WIDTH            16

// Default command opcodes, overridable per instance
`define OP_READ_STATUS_DEF    8'h70
`define OP_CLEAR_STATUS_DEF   8'h50
`define OP_PROG_SETUP_DEF     8'h40
`define OP_ERASE_SETUP_DEF    8'h20
`define OP_LOCK_SETUP_DEF     8'h60
`define OP_STREAM_SETUP_DEF   8'h30

`endif

// ==== verilog/status_cell.v ====
// Sticky status bits of one partition
`timescale 1ns/1ns
`include "flash_status_regs.vh"

module status_cell (
    // Clock and reset
    input  wire       clock_i,
    input  wire       rst_i,
    // Engine events aimed at this partition
    input  wire       erase_suspend_i,
    input  wire       program_suspend_i,
    input  wire       resume_i,
    input  wire       erase_fail_i,
    input  wire       program_fail_i,
    input  wire       seq_error_i,
    input  wire       lock_abort_i,
    input  wire       op_done_i,
    input  wire       vpp_low_i,
    // Clear-status command for this partition
    input  wire       clear_i,
    // Stored bits 6..1
    output wire [5:0] sticky_o
);

    reg erase_suspended_flag_q;
    reg erase_fail_flag_q;
    reg program_fail_flag_q;
    reg program_voltage_low_flag_q;
    reg program_suspended_flag_q;
    reg locked_block_abort_flag_q;

    // Set wins over clear on every bit
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            erase_suspended_flag_q     <= 1'b0;
            erase_fail_flag_q          <= 1'b0;
            program_fail_flag_q        <= 1'b0;
            program_voltage_low_flag_q <= 1'b0;
            program_suspended_flag_q   <= 1'b0;
            locked_block_abort_flag_q  <= 1'b0;
        end else begin
            // Suspend bits: engine may clear on resume
            if (erase_suspend_i)
                erase_suspended_flag_q <= 1'b1;
            else if (resume_i || clear_i)
                erase_suspended_flag_q <= 1'b0;
            if (program_suspend_i)
                program_suspended_flag_q <= 1'b1;
            else if (resume_i || clear_i)
                program_suspended_flag_q <= 1'b0;
            // Error bits: only the clear command removes them
            if (erase_fail_i || seq_error_i)
                erase_fail_flag_q <= 1'b1;
            else if (clear_i)
                erase_fail_flag_q <= 1'b0;
            if (program_fail_i || seq_error_i)
                program_fail_flag_q <= 1'b1;
            else if (clear_i)
                program_fail_flag_q <= 1'b0;
            if (op_done_i && vpp_low_i)
                program_voltage_low_flag_q <= 1'b1;
            else if (clear_i)
                program_voltage_low_flag_q <= 1'b0;
            if (lock_abort_i)
                locked_block_abort_flag_q <= 1'b1;
            else if (clear_i)
                locked_block_abort_flag_q <= 1'b0;
        end
    end

    assign sticky_o = {erase_suspended_flag_q, erase_fail_flag_q, program_fail_flag_q,
                       program_voltage_low_flag_q, program_suspended_flag_q, locked_block_abort_flag_q};

endmodule // status_cell

// ==== verilog/partition_status_unit.v ====
// Per-partition status register, read-status mode and clear-status logic
`timescale 1ns/1ns
`include "flash_status_regs.vh"

module partition_status_unit #(
    parameter       NUM_PARTS       = `NUM_PARTITIONS,
    parameter       PART_BITS       = `PART_ADDR_BITS,
    parameter [7:0] OP_READ_STATUS  = `OP_READ_STATUS_DEF,
    parameter [7:0] OP_CLEAR_STATUS = `OP_CLEAR_STATUS_DEF,
    parameter [7:0] OP_PROG_SETUP   = `OP_PROG_SETUP_DEF,
    parameter [7:0] OP_ERASE_SETUP  = `OP_ERASE_SETUP_DEF,
    parameter [7:0] OP_LOCK_SETUP   = `OP_LOCK_SETUP_DEF,
    parameter [7:0] OP_STREAM_SETUP = `OP_STREAM_SETUP_DEF
) (
    // Clock and reset
    input  wire                   clock_i,
    input  wire                   rst_i,
    // Flash bus, sampled synchronously
    input  wire                   chip_en_n_i,
    input  wire                   out_en_n_i,
    input  wire                   write_en_n_i,
    input  wire                   burst_read_i,
    input  wire [PART_BITS-1:0]   part_addr_i,
    input  wire [15:0]            data_i,
    // Write state machine report
    input  wire                   engine_busy_i,
    input  wire [PART_BITS-1:0]   engine_part_i,
    input  wire                   stream_active_i,
    input  wire                   stream_word_busy_i,
    input  wire                   vpp_low_i,
    // Write state machine event pulses, for engine_part_i
    input  wire                   erase_suspend_i,
    input  wire                   program_suspend_i,
    input  wire                   resume_i,
    input  wire                   erase_fail_i,
    input  wire                   program_fail_i,
    input  wire                   seq_error_i,
    input  wire                   lock_abort_i,
    input  wire                   op_done_i,
    // Read data path
    output reg  [15:0]            data_o,
    output reg                    data_oe_o,
    // Partition read modes
    output reg  [NUM_PARTS-1:0]   status_mode_o,
    output reg                    burst_refused_o
);

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_READ  = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;

    // Partition index to one-hot select
    function [NUM_PARTS-1:0] part_decode;
        input [PART_BITS-1:0] idx;
        integer k;
        begin
            part_decode = {NUM_PARTS{1'b0}};
            for (k = 0; k < NUM_PARTS; k = k + 1) begin
                if (idx == k[PART_BITS-1:0])
                    part_decode[k] = 1'b1;
            end
        end
    endfunction

    // Opcode that opens a two-cycle sequence
    function is_setup;
        input [7:0] op;
        begin
            is_setup = (op == OP_PROG_SETUP) || (op == OP_ERASE_SETUP) ||
                       (op == OP_LOCK_SETUP) || (op == OP_STREAM_SETUP);
        end
    endfunction

    reg  [2:0]           bus_state_q;
    reg  [2:0]           bus_state_d;
    reg  [PART_BITS-1:0] wr_part_q;
    reg  [7:0]           wr_cmd_q;
    reg  [NUM_PARTS-1:0] pending_setup_q;
    reg  [NUM_PARTS-1:0] clear_pulse_q;

    wire                 read_active;
    wire                 write_active;
    wire                 cmd_taken;
    wire                 read_start;
    wire [NUM_PARTS-1:0] wr_sel;
    wire [NUM_PARTS-1:0] ev_sel;
    wire [NUM_PARTS-1:0] rd_sel;
    wire [NUM_PARTS*6-1:0] sticky_all;
    wire [NUM_PARTS-1:0] part_busy_bit;
    wire                 engine_ready;

    assign read_active  = !chip_en_n_i && !out_en_n_i && write_en_n_i;
    assign write_active = !chip_en_n_i && !write_en_n_i;
    assign wr_sel       = part_decode(wr_part_q);
    assign ev_sel       = part_decode(engine_part_i);
    assign rd_sel       = part_decode(part_addr_i);
    assign engine_ready = !engine_busy_i;

    // Bus cycle tracker
    always @* begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            ST_IDLE: begin
                if (write_active)
                    bus_state_d = ST_WRITE;
                else if (read_active)
                    bus_state_d = ST_READ;
            end
            ST_READ: begin
                if (!read_active)
                    bus_state_d = write_active ? ST_WRITE : ST_IDLE;
            end
            ST_WRITE: begin
                if (!write_active)
                    bus_state_d = ST_IDLE;
            end
            default: bus_state_d = ST_IDLE;
        endcase
    end

    // Command taken as the write strobe ends
    assign cmd_taken  = (bus_state_q == ST_WRITE) && !write_active;
    // A read opens once both enables are low with write enable high
    assign read_start = (bus_state_q != ST_READ) && (bus_state_d == ST_READ);

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state_q <= ST_IDLE;
            wr_part_q   <= {PART_BITS{1'b0}};
            wr_cmd_q    <= 8'h00;
        end else begin
            bus_state_q <= bus_state_d;
            if (write_active) begin
                wr_part_q <= part_addr_i;
                wr_cmd_q  <= data_i[7:0];
            end
        end
    end

    // Per-partition read mode
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_mode_o   <= {NUM_PARTS{1'b0}};
            pending_setup_q <= {NUM_PARTS{1'b0}};
            clear_pulse_q   <= {NUM_PARTS{1'b0}};
        end else begin
            clear_pulse_q <= {NUM_PARTS{1'b0}};
            if (cmd_taken) begin
                // Only the addressed partition changes mode
                if (pending_setup_q[wr_part_q]) begin
                    status_mode_o[wr_part_q]   <= 1'b1;
                    pending_setup_q[wr_part_q] <= 1'b0;
                end else if (wr_cmd_q == OP_READ_STATUS) begin
                    status_mode_o[wr_part_q] <= 1'b1;
                end else if (wr_cmd_q == OP_CLEAR_STATUS) begin
                    // Mode left as is; voltage level not consulted
                    clear_pulse_q <= wr_sel;
                end else if (is_setup(wr_cmd_q)) begin
                    status_mode_o[wr_part_q]   <= 1'b1;
                    pending_setup_q[wr_part_q] <= 1'b1;
                end else begin
                    status_mode_o[wr_part_q] <= 1'b0;
                end
            end
        end
    end

    // Status bit storage, one cell per partition
    genvar g;
    generate
        for (g = 0; g < NUM_PARTS; g = g + 1) begin : g_part
            status_cell u_cell (
                .clock_i           (clock_i),
                .rst_i             (rst_i),
                .erase_suspend_i   (erase_suspend_i && ev_sel[g]),
                .program_suspend_i (program_suspend_i && ev_sel[g]),
                .resume_i          (resume_i && ev_sel[g]),
                .erase_fail_i      (erase_fail_i && ev_sel[g]),
                .program_fail_i    (program_fail_i && ev_sel[g]),
                .seq_error_i       (seq_error_i && ev_sel[g]),
                .lock_abort_i      (lock_abort_i && ev_sel[g]),
                .op_done_i         (op_done_i && ev_sel[g]),
                .vpp_low_i         (vpp_low_i),
                .clear_i           (clear_pulse_q[g]),
                .sticky_o          (sticky_all[g*6 +: 6])
            );
            // Busy encoding; never set while the engine is ready
            assign part_busy_bit[g] = engine_busy_i &&
                                      (stream_active_i ? stream_word_busy_i : !ev_sel[g]);
        end
    endgenerate

    // Snapshot mux for the addressed partition
    reg [7:0] status_now;
    integer   m;
    always @* begin
        status_now = 8'h00;
        for (m = 0; m < NUM_PARTS; m = m + 1) begin
            if (rd_sel[m])
                status_now = {engine_ready, sticky_all[m*6 +: 6], part_busy_bit[m]};
        end
    end

    // Read path: latch on read start, drive while a non-burst read of a status-mode partition stands
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            data_o          <= `DATA_RESET;
            data_oe_o       <= 1'b0;
            burst_refused_o <= 1'b0;
        end else begin
            burst_refused_o <= 1'b0;
            if (read_start) begin
                data_o <= {`STATUS_HIGH_BYTE, status_now};
            end
            if (read_active && status_mode_o[part_addr_i]) begin
                if (burst_read_i) begin
                    data_oe_o       <= 1'b0;
                    burst_refused_o <= read_start;
                end else begin
                    data_oe_o <= 1'b1;
                end
            end else begin
                data_oe_o <= 1'b0;
            end
        end
    end

endmodule // partition_status_unit

// ==== bench/status_chk_assertions.sv ====
// Port checker for the partition status unit
`timescale 1ns/1ns
module status_chk #(
    parameter NUM_PARTS = 8,
    parameter PART_BITS = 3
) (
    input wire                 clock_i,
    input wire                 rst_i,
    input wire                 chip_en_n_i,
    input wire                 out_en_n_i,
    input wire                 write_en_n_i,
    input wire                 burst_read_i,
    input wire [PART_BITS-1:0] part_addr_i,
    input wire                 engine_busy_i,
    input wire [PART_BITS-1:0] engine_part_i,
    input wire                 stream_active_i,
    input wire                 stream_word_busy_i,
    input wire [15:0]          data_o,
    input wire                 data_oe_o,
    input wire [NUM_PARTS-1:0] status_mode_o,
    input wire                 burst_refused_o
);
    reg  rd_q;
    reg  wr_q;
    wire rd = !chip_en_n_i & !out_en_n_i & write_en_n_i;
    wire wr = !chip_en_n_i & !write_en_n_i;
    wire rs = rd & !rd_q;
    wire tk = wr_q & !wr;
    wire sm = status_mode_o[part_addr_i];
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            {rd_q, wr_q} <= 2'b00;
        end else begin
            {rd_q, wr_q} <= {rd, wr};
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_high_zero: assert property (data_oe_o |-> data_o[15:8] == 8'h00)
        else $error("high byte not zero");
    chk_ready_bit: assert property (rs |=> data_o[7] == !$past(engine_busy_i))
        else $error("ready bit wrong");
    chk_own_busy: assert property (rs && engine_busy_i && !stream_active_i
        |=> data_o[0] == ($past(engine_part_i) != $past(part_addr_i))) else $error("busy owner bit wrong");
    chk_idle_bit: assert property (rs && !engine_busy_i |=> !data_o[0])
        else $error("idle bit0 set");
    chk_stream_bit: assert property (rs && stream_active_i && engine_busy_i
        |=> data_o[0] == $past(stream_word_busy_i)) else $error("stream bit wrong");
    chk_snap_hold: assert property (!rs |=> $stable(data_o))
        else $error("snapshot changed mid read");
    chk_oe_status: assert property (rd && !burst_read_i && sm |=> data_oe_o)
        else $error("status not driven");
    chk_oe_drop: assert property (!rd || !sm || burst_read_i |=> !data_oe_o)
        else $error("data driven wrongly");
    chk_burst_flag: assert property (rs && burst_read_i && sm |=> burst_refused_o)
        else $error("burst not refused");
    chk_mode_cause: assert property ($changed(status_mode_o) |-> $past(tk) || $past(tk, 2))
        else $error("mode changed without command");
    cover property (rs && sm);
    cover property (burst_refused_o);
    cover property (tk);
endmodule // status_chk

// ==== bench/flash_host.sv ====
// Host bus model issuing commands and reads
`timescale 1ns/1ns
module flash_host (
    // Clock and returned read data
    input  wire        clock_i,
    input  wire [15:0] rd_data_i,
    input  wire        rd_oe_i,
    input  wire        refused_i,
    // Bus strobes, address and data
    output reg         ce_n_o,
    output reg         oe_n_o,
    output reg         we_n_o,
    output reg         burst_o,
    output reg  [2:0]  part_o,
    output reg  [15:0] wdata_o
);
    initial begin
        {ce_n_o, oe_n_o, we_n_o, burst_o} = 4'b1110;
        part_o = 3'h0;
        wdata_o = 16'h0000;
    end
    // Command write, released bus shows inverted data
    task write_cmd(input [2:0] p, input [7:0] op);
        begin
            @(negedge clock_i);
            {ce_n_o, we_n_o} = 2'b00;
            part_o = p;
            wdata_o = {8'h00, op};
            @(negedge clock_i);
            {ce_n_o, we_n_o} = 2'b11;
            wdata_o = ~wdata_o;
            repeat (2) @(negedge clock_i);
        end
    endtask
    // Single read, burst only to provoke refusal
    task read_word(input [2:0] p, input b, output [15:0] d, output oe, output rf);
        begin
            @(negedge clock_i);
            {ce_n_o, oe_n_o} = 2'b00;
            part_o = p;
            burst_o = b;
            @(negedge clock_i);
            d = rd_data_i;
            oe = rd_oe_i;
            rf = refused_i;
            {ce_n_o, oe_n_o, burst_o} = 3'b110;
            @(negedge clock_i);
        end
    endtask
endmodule // flash_host

// ==== bench/testbench.sv ====
// Self-checking bench for the partition status unit
`timescale 1ns/1ns
module testbench;
    reg         clock_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         engine_busy_i = 1'b0;
    reg  [2:0]  engine_part_i = 3'h0;
    reg         stream_active_i = 1'b0;
    reg         stream_word_busy_i = 1'b0;
    reg         vpp_low_i = 1'b0;
    reg  [7:0]  ev = 8'h00;
    wire        ce_n, oe_n, we_n, burst, data_oe, refused;
    wire [2:0]  part;
    wire [15:0] wdata, rdata;
    wire [7:0]  mode;
    reg  [15:0] d;
    reg         oe, rf;
    integer     i, failures = 0, samples_checked = 0;
    logic [7:0] exp_t [0:7] = '{8'hc0, 8'h84, 8'h80, 8'ha0, 8'h90, 8'hb0, 8'h82, 8'h88};
    logic [7:0] ops [0:3] = '{8'h40, 8'h20, 8'h60, 8'h30};
    always #5 clock_i = ~clock_i;
    partition_status_unit uut (
        .clock_i(clock_i), .rst_i(rst_i), .chip_en_n_i(ce_n), .out_en_n_i(oe_n),
        .write_en_n_i(we_n), .burst_read_i(burst), .part_addr_i(part), .data_i(wdata),
        .engine_busy_i(engine_busy_i), .engine_part_i(engine_part_i), .stream_active_i(stream_active_i),
        .stream_word_busy_i(stream_word_busy_i), .vpp_low_i(vpp_low_i), .erase_suspend_i(ev[0]),
        .program_suspend_i(ev[1]), .resume_i(ev[2]), .erase_fail_i(ev[3]), .program_fail_i(ev[4]),
        .seq_error_i(ev[5]), .lock_abort_i(ev[6]), .op_done_i(ev[7]), .data_o(rdata),
        .data_oe_o(data_oe), .status_mode_o(mode), .burst_refused_o(refused));
    flash_host host (
        .clock_i(clock_i), .rd_data_i(rdata), .rd_oe_i(data_oe), .refused_i(refused),
        .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .burst_o(burst), .part_o(part), .wdata_o(wdata));
    task check(input string nm, input [16:0] seen, input [16:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task pulse(input [2:0] k, input [2:0] p);
        begin
            @(negedge clock_i);
            ev = 8'h01 << k;
            engine_part_i = p;
            @(negedge clock_i);
            ev = 8'h00;
        end
    endtask
    task rd_chk(input string nm, input [2:0] p, input [16:0] exp);
        begin
            host.read_word(p, 1'b0, d, oe, rf);
            check(nm, {oe, d}, exp);
        end
    endtask
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #40000;
        failures = failures + 1;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        host.write_cmd(3'd2, 8'h70);
        check("mode", {9'h000, mode}, 17'h00004);
        rd_chk("reset sr", 3'd2, 17'h10080);
        rd_chk("array read", 3'd3, 17'h00080);
        host.read_word(3'd2, 1'b1, d, oe, rf);
        check("burst", {15'h0000, oe, rf}, 17'h00001);
        host.write_cmd(3'd1, 8'h70);
        vpp_low_i = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            pulse(i[2:0], 3'd1);
            rd_chk("event sr", 3'd1, {9'h100, exp_t[i]});
            host.write_cmd(3'd1, 8'h50);
            rd_chk("cleared sr", 3'd1, 17'h10080);
            check("mode kept", {9'h000, mode}, 17'h00006);
        end
        pulse(3'd3, 3'd1);
        pulse(3'd0, 3'd1);
        pulse(3'd2, 3'd1);
        rd_chk("resume sr", 3'd1, 17'h100a0);
        host.write_cmd(3'd1, 8'h50);
        engine_busy_i = 1'b1;
        rd_chk("own busy", 3'd1, 17'h10000);
        rd_chk("other busy", 3'd2, 17'h10001);
        stream_active_i = 1'b1;
        stream_word_busy_i = 1'b1;
        rd_chk("word busy", 3'd1, 17'h10001);
        stream_word_busy_i = 1'b0;
        rd_chk("word done", 3'd1, 17'h10000);
        {stream_word_busy_i, engine_busy_i} = 2'b10;
        rd_chk("stream exit", 3'd1, 17'h10080);
        {stream_active_i, stream_word_busy_i} = 2'b00;
        for (i = 0; i < 4; i = i + 1) begin
            host.write_cmd(3'd5, ops[i]);
            check("setup mode", {9'h000, mode}, 17'h00026);
            rd_chk("setup sr", 3'd5, 17'h10080);
            host.write_cmd(3'd5, 8'hd0);
            check("confirm mode", {9'h000, mode}, 17'h00026);
            host.write_cmd(3'd5, 8'hff);
            check("left mode", {9'h000, mode}, 17'h00006);
        end
        pulse(3'd4, 3'd2);
        rd_chk("fail before reset", 3'd2, 17'h10090);
        @(negedge clock_i);
        rst_i = 1'b1;
        @(negedge clock_i);
        rst_i = 1'b0;
        check("reset mode", {9'h000, mode}, 17'h00000);
        host.write_cmd(3'd2, 8'h70);
        rd_chk("after reset", 3'd2, 17'h10080);
        complete_run;
    end
endmodule // testbench
bind partition_status_unit status_chk #(.NUM_PARTS(NUM_PARTS), .PART_BITS(PART_BITS)) chk (
    .clock_i(clock_i), .rst_i(rst_i), .chip_en_n_i(chip_en_n_i), .out_en_n_i(out_en_n_i),
    .write_en_n_i(write_en_n_i), .burst_read_i(burst_read_i), .part_addr_i(part_addr_i),
    .engine_busy_i(engine_busy_i), .engine_part_i(engine_part_i), .stream_active_i(stream_active_i),
    .stream_word_busy_i(stream_word_busy_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .status_mode_o(status_mode_o), .burst_refused_o(burst_refused_o));
